// file: rtl/gtc_pkg.sv
// package for the global transceiver control block: register map, fields, timing
// assumes a single 40 MHz master clock domain and an 8-bit register port
package gtc_pkg;

    // register port geometry
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 8;

    // register addresses
    localparam logic [11:0] ADDR_GLOBAL_CONTROL_ONE = 12'h0F0;
    localparam logic [11:0] ADDR_GLOBAL_FRAMER_CONTROL = 12'h0F1;
    localparam logic [11:0] ADDR_GLOBAL_TRANSCEIVER_CONTROL_TWO = 12'h0F2;
    localparam logic [11:0] ADDR_GLOBAL_CLOCK_CONTROL = 12'h0F3;

    // reset values
    localparam logic [7:0] RESET_GLOBAL_CONTROL_ONE = 8'h00;
    localparam logic [7:0] RESET_GLOBAL_FRAMER_CONTROL = 8'h00;
    localparam logic [7:0] RESET_GLOBAL_TRANSCEIVER_CONTROL_TWO = 8'h00;
    localparam logic [7:0] RESET_GLOBAL_CLOCK_CONTROL = 8'h00;

    // implemented bits; everything else is stored as zero and reads zero
    localparam logic [7:0] MASK_GLOBAL_CONTROL_ONE = 8'h01;
    localparam logic [7:0] MASK_GLOBAL_TRANSCEIVER_CONTROL_TWO = 8'h06;

    // field positions, control one
    localparam int unsigned POS_INTERRUPT_PIN_INHIBIT = 0;
    // field positions, framer control
    localparam int unsigned POS_INTERLEAVE_MUX_MODE = 6;
    localparam int unsigned POS_BACKPLANE_CLOCK_SELECT = 4;
    localparam int unsigned POS_LOSS_FREEZE_PIN_SELECT = 3;
    localparam int unsigned POS_RX_SYNC_PIN_SELECT = 2;
    localparam int unsigned POS_TX_BLOCK_CLOCK_SELECT = 1;
    localparam int unsigned POS_RX_BLOCK_CLOCK_SELECT = 0;
    // field positions, transceiver control two
    localparam int unsigned POS_LOSS_SOURCE_SELECT = 2;
    localparam int unsigned POS_TX_SYNC_DIRECTION_SELECT = 1;
    // field positions, clock control
    localparam int unsigned POS_BACKPLANE_REFERENCE_SELECT = 4;
    localparam int unsigned POS_BACKPLANE_FREQUENCY_BIT = 3;
    localparam int unsigned POS_MASTER_FREQUENCY_FAMILY = 2;
    localparam int unsigned POS_MASTER_PERIOD_SELECT = 0;

    // backplane reference select codes
    localparam logic [3:0] REF_LAST_RECOVERED = 4'h7;
    localparam logic [3:0] REF_DERIVED_T1 = 4'h8;
    localparam logic [3:0] REF_DERIVED_E1 = 4'h9;
    localparam logic [3:0] REF_EXTERNAL = 4'hA;

    // kind of backplane reference in use
    typedef enum logic [1:0] {
        GTC_REF_RECOVERED = 2'b00,
        GTC_REF_DERIVED = 2'b01,
        GTC_REF_EXTERNAL = 2'b11,
        GTC_REF_RESERVED = 2'b10
    } gtc_ref_kind_t;

    // clock and timing
    localparam int unsigned MCLK_PERIOD_NS = 25;
    localparam int unsigned MCLK_KHZ = 1000000 / MCLK_PERIOD_NS;
    localparam int unsigned NCO_W = 24;
    localparam int unsigned BP_BASE_KHZ = 2048;
    localparam int unsigned DERIVED_T1_KHZ = 1544;
    localparam int unsigned DERIVED_E1_KHZ = 2048;
    localparam int unsigned FRAME_RATE_KHZ = 8;
    localparam int unsigned FRAME_BASE_EDGES = BP_BASE_KHZ / FRAME_RATE_KHZ;

    // phase increment of a numerically controlled oscillator on the master clock
    function automatic logic [NCO_W-1:0] nco_inc(input int unsigned f_khz);
        return NCO_W'((64'(f_khz) << NCO_W) / 64'(MCLK_KHZ));
    endfunction : nco_inc

    localparam logic [NCO_W-1:0] INC_BP_BASE = nco_inc(BP_BASE_KHZ);
    localparam logic [NCO_W-1:0] INC_DERIVED_T1 = nco_inc(DERIVED_T1_KHZ);
    localparam logic [NCO_W-1:0] INC_DERIVED_E1 = nco_inc(DERIVED_E1_KHZ);

    // external master clock rate in kHz, indexed by {family, period select}
    localparam logic [14:0] MASTER_KHZ [0:7] = '{
        15'h0800, 15'h1000, 15'h2000, 15'h4000,
        15'h0608, 15'h0C10, 15'h1820, 15'h3040
    };

endpackage : gtc_pkg

// file: rtl/gtc_sync3.sv
// triple flip-flop synchroniser for pins from outside the master clock domain
// assumes one clock; a bit changes once the second and third stages agree
`timescale 1ns/1ps
module gtc_sync3 #(
    parameter int unsigned WIDTH = 1
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // asynchronous pins and their filtered image
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;
    logic [WIDTH-1:0] stage3_q;
    logic [WIDTH-1:0] agree;

    assign agree = ~(stage2_q ^ stage3_q);

    // only the second stage reads the first; accept a bit when the late stages match
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stage1_q <= '0;
            stage2_q <= '0;
            stage3_q <= '0;
            sync_out <= '0;
        end else begin
            stage1_q <= async_in;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
            sync_out <= (sync_out & ~agree) | (stage3_q & agree);
        end
    end

endmodule : gtc_sync3

// file: rtl/gtc_top.sv
// global control registers and the shared pins they steer
// assumes per-port inputs on mclk; outside pins pass gtc_sync3
// Functional notes
// (RQ1) inhibit bit forces interrupt output inactive high
// (RQ2) interleave mode field configures bus multiplexer
// (RQ3) software matches framer interleave settings
// (RQ4) backplane select sets output clock rate
// (RQ5) loss/freeze select picks loss or freeze
// (RQ6) loss source picks line or framer loss
// (RQ7) sync select picks frame or multiframe sync
// (RQ8) transmit pin shows block or clock
// (RQ9) receive pin shows block or clock
// (RQ10) direction set drives 8kHz frame pulse out
// (RQ11) direction clear: outside supplies frame pulse
// (RQ12) frequency bit marks reference T1 or E1
// (RQ13) software matches frequency bit to port
// (RQ14) family bit marks master clock rate family
// (RQ15) period bits pick master clock multiple
// (RQ16) codes 0-7 pick recovered port clocks
// (RQ17) codes 8/9 derive reference, pin driven; 8 with frequency bit clear or 9 with it set is treated as reserved
// (RQ18) code 10 takes reference from pin input
// (RQ19) software writes zeros to reserved bits
// (RQ20) other reference codes are reserved
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module gtc_top #(
    parameter int unsigned PORTS = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // register port
    input wire logic [gtc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [gtc_pkg::DATA_W-1:0] reg_wr_data,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [gtc_pkg::DATA_W-1:0] reg_rd_data,
    // interrupt
    input wire logic irq_unmasked_any,
    output logic interrupt_out_n,
    // interleaved bus
    output logic [1:0] interleave_mux_mode,
    output logic interleaved_bus_enable,
    output logic [3:0] interleaved_bus_devices,
    // master clock description
    output logic master_frequency_family,
    output logic [1:0] master_period_select,
    output logic [14:0] master_clock_khz,
    // backplane clock and reference
    input wire logic [PORTS-1:0] rx_recovered_clock,
    input wire logic reference_clock_pin_in,
    output logic reference_clock_pin_out,
    output logic reference_clock_pin_oe,
    output logic backplane_clock_out,
    output logic backplane_reference_clock,
    output logic backplane_reference_is_t1,
    output logic backplane_reference_valid,
    // transmit system sync pin
    input wire logic tx_system_sync_pin_in,
    output logic tx_system_sync_pin_out,
    output logic tx_system_sync_pin_oe,
    output logic tx_frame_sync,
    // shared per-port pins
    input wire logic [PORTS-1:0] framer_loss,
    input wire logic [PORTS-1:0] rx_line_loss,
    input wire logic [PORTS-1:0] rx_signaling_freeze,
    output logic [PORTS-1:0] loss_or_freeze_pin,
    input wire logic [PORTS-1:0] rx_frame_sync,
    input wire logic [PORTS-1:0] rx_multiframe_sync,
    output logic [PORTS-1:0] rx_sync_pin,
    input wire logic [PORTS-1:0] tx_channel_block,
    input wire logic [PORTS-1:0] tx_channel_clock,
    output logic [PORTS-1:0] tx_channel_pin,
    input wire logic [PORTS-1:0] rx_channel_block,
    input wire logic [PORTS-1:0] rx_channel_clock,
    output logic [PORTS-1:0] rx_channel_pin
);

    logic [7:0] global_control_one_q;
    logic [7:0] global_framer_control_q;
    logic [7:0] global_transceiver_control_two_q;
    logic [7:0] global_clock_control_q;

    logic interrupt_pin_inhibit;
    logic [1:0] backplane_clock_select;
    logic loss_freeze_pin_select;
    logic rx_sync_pin_select;
    logic tx_block_clock_select;
    logic rx_block_clock_select;
    logic loss_source_select;
    logic tx_sync_direction_select;
    logic [3:0] backplane_reference_select;
    logic backplane_frequency_bit;

    logic [PORTS-1:0] recovered_sync;
    logic ref_pin_sync;
    logic tx_sync_pin_sync;

    gtc_pkg::gtc_ref_kind_t ref_kind;
    logic [gtc_pkg::NCO_W-1:0] bp_inc;
    logic [gtc_pkg::NCO_W-1:0] bp_phase_q;
    logic [gtc_pkg::NCO_W-1:0] derived_inc;
    logic [gtc_pkg::NCO_W-1:0] derived_phase_q;
    logic bp_clk_prev_q;
    logic bp_rise;
    logic [10:0] frame_count_q;
    logic [10:0] frame_last;
    logic frame_pulse_q;
    logic [PORTS-1:0] selected_loss;
    logic [1:0] mux_mode_field;

    // field views of the stored registers
    assign interrupt_pin_inhibit = global_control_one_q[gtc_pkg::POS_INTERRUPT_PIN_INHIBIT];
    assign backplane_clock_select =
        global_framer_control_q[gtc_pkg::POS_BACKPLANE_CLOCK_SELECT +: 2];
    assign loss_freeze_pin_select = global_framer_control_q[gtc_pkg::POS_LOSS_FREEZE_PIN_SELECT];
    assign rx_sync_pin_select = global_framer_control_q[gtc_pkg::POS_RX_SYNC_PIN_SELECT];
    assign tx_block_clock_select = global_framer_control_q[gtc_pkg::POS_TX_BLOCK_CLOCK_SELECT];
    assign rx_block_clock_select = global_framer_control_q[gtc_pkg::POS_RX_BLOCK_CLOCK_SELECT];
    assign loss_source_select =
        global_transceiver_control_two_q[gtc_pkg::POS_LOSS_SOURCE_SELECT];
    assign tx_sync_direction_select =
        global_transceiver_control_two_q[gtc_pkg::POS_TX_SYNC_DIRECTION_SELECT];
    assign backplane_reference_select =
        global_clock_control_q[gtc_pkg::POS_BACKPLANE_REFERENCE_SELECT +: 4];
    assign backplane_frequency_bit = global_clock_control_q[gtc_pkg::POS_BACKPLANE_FREQUENCY_BIT];
    assign mux_mode_field = global_framer_control_q[gtc_pkg::POS_INTERLEAVE_MUX_MODE +: 2];

    // register writes; bits with no function are dropped
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            global_control_one_q <= gtc_pkg::RESET_GLOBAL_CONTROL_ONE;
            global_framer_control_q <= gtc_pkg::RESET_GLOBAL_FRAMER_CONTROL;
            global_transceiver_control_two_q <= gtc_pkg::RESET_GLOBAL_TRANSCEIVER_CONTROL_TWO;
            global_clock_control_q <= gtc_pkg::RESET_GLOBAL_CLOCK_CONTROL;
        end else if (reg_wr) begin
            if (reg_addr == gtc_pkg::ADDR_GLOBAL_CONTROL_ONE) begin
                global_control_one_q <= reg_wr_data & gtc_pkg::MASK_GLOBAL_CONTROL_ONE; // RQ19
            end else if (reg_addr == gtc_pkg::ADDR_GLOBAL_FRAMER_CONTROL) begin
                global_framer_control_q <= reg_wr_data;
            end else if (reg_addr == gtc_pkg::ADDR_GLOBAL_TRANSCEIVER_CONTROL_TWO) begin
                global_transceiver_control_two_q <=
                    reg_wr_data & gtc_pkg::MASK_GLOBAL_TRANSCEIVER_CONTROL_TWO; // RQ19
            end else if (reg_addr == gtc_pkg::ADDR_GLOBAL_CLOCK_CONTROL) begin
                global_clock_control_q <= reg_wr_data;
            end
        end
    end

    // read data one cycle after the strobe, zero otherwise and for unmapped addresses
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reg_rd_data <= '0;
        end else if (!reg_rd) begin
            reg_rd_data <= '0;
        end else if (reg_addr == gtc_pkg::ADDR_GLOBAL_CONTROL_ONE) begin
            reg_rd_data <= global_control_one_q;
        end else if (reg_addr == gtc_pkg::ADDR_GLOBAL_FRAMER_CONTROL) begin
            reg_rd_data <= global_framer_control_q;
        end else if (reg_addr == gtc_pkg::ADDR_GLOBAL_TRANSCEIVER_CONTROL_TWO) begin
            reg_rd_data <= global_transceiver_control_two_q;
        end else if (reg_addr == gtc_pkg::ADDR_GLOBAL_CLOCK_CONTROL) begin
            reg_rd_data <= global_clock_control_q;
        end else begin
            reg_rd_data <= '0;
        end
    end

    // interrupt pin, inactive high while inhibited
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            interrupt_out_n <= 1'b1;
        end else begin
            interrupt_out_n <= ~(irq_unmasked_any & ~interrupt_pin_inhibit); // RQ1
        end
    end

    // interleaved bus configuration; framers must be set to agree (RQ3)
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            interleave_mux_mode <= 2'h0;
            interleaved_bus_enable <= 1'b0;
            interleaved_bus_devices <= 4'h0;
        end else begin
            interleave_mux_mode <= mux_mode_field;
            interleaved_bus_enable <= (mux_mode_field != 2'h0);
            interleaved_bus_devices <= (mux_mode_field == 2'h0) ? 4'h0 : 4'h1 << mux_mode_field; // RQ2
        end
    end

    // description of the external master clock
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            master_frequency_family <= 1'b0;
            master_period_select <= 2'h0;
            master_clock_khz <= gtc_pkg::MASTER_KHZ[0];
        end else begin
            master_frequency_family <=
                global_clock_control_q[gtc_pkg::POS_MASTER_FREQUENCY_FAMILY]; // RQ14
            master_period_select <= global_clock_control_q[gtc_pkg::POS_MASTER_PERIOD_SELECT +: 2];
            master_clock_khz <= gtc_pkg::MASTER_KHZ[
                global_clock_control_q[gtc_pkg::POS_MASTER_PERIOD_SELECT +: 3]]; // RQ15
        end
    end

    // pins from outside the clock domain
    gtc_sync3 #(.WIDTH(PORTS)) u_sync_recovered (
        .mclk(mclk),
        .rst(rst),
        .async_in(rx_recovered_clock),
        .sync_out(recovered_sync)
    );

    gtc_sync3 #(.WIDTH(2)) u_sync_pins (
        .mclk(mclk),
        .rst(rst),
        .async_in({tx_system_sync_pin_in, reference_clock_pin_in}),
        .sync_out({tx_sync_pin_sync, ref_pin_sync})
    );

    // classify the reference code against the frequency bit
    always_comb begin
        ref_kind = gtc_pkg::GTC_REF_RESERVED; // RQ20
        derived_inc = '0;
        if (backplane_reference_select <= gtc_pkg::REF_LAST_RECOVERED) begin
            ref_kind = gtc_pkg::GTC_REF_RECOVERED; // RQ16
        end else if (backplane_reference_select == gtc_pkg::REF_DERIVED_T1 &&
                     backplane_frequency_bit) begin
            ref_kind = gtc_pkg::GTC_REF_DERIVED; // RQ17
            derived_inc = gtc_pkg::INC_DERIVED_T1;
        end else if (backplane_reference_select == gtc_pkg::REF_DERIVED_E1 &&
                     !backplane_frequency_bit) begin
            ref_kind = gtc_pkg::GTC_REF_DERIVED; // RQ17
            derived_inc = gtc_pkg::INC_DERIVED_E1;
        end else if (backplane_reference_select == gtc_pkg::REF_EXTERNAL) begin
            ref_kind = gtc_pkg::GTC_REF_EXTERNAL; // RQ18
        end
    end

    // derived reference oscillator, jitter one master period; pin driven only for it
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            derived_phase_q <= '0;
            reference_clock_pin_oe <= 1'b0;
            reference_clock_pin_out <= 1'b0;
        end else begin
            derived_phase_q <= derived_phase_q + derived_inc;
            reference_clock_pin_oe <= (ref_kind == gtc_pkg::GTC_REF_DERIVED); // RQ17
            reference_clock_pin_out <= derived_phase_q[gtc_pkg::NCO_W-1];
        end
    end

    // selected reference and its nominal rate
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            backplane_reference_clock <= 1'b0;
            backplane_reference_is_t1 <= 1'b0;
            backplane_reference_valid <= 1'b0;
        end else begin
            backplane_reference_is_t1 <= backplane_frequency_bit; // RQ12
            backplane_reference_valid <= (ref_kind != gtc_pkg::GTC_REF_RESERVED);
            backplane_reference_clock <= (ref_kind == gtc_pkg::GTC_REF_RECOVERED) ?
                recovered_sync[backplane_reference_select[2:0]] : // RQ16
                (ref_kind == gtc_pkg::GTC_REF_DERIVED) ? derived_phase_q[gtc_pkg::NCO_W-1] :
                (ref_kind == gtc_pkg::GTC_REF_EXTERNAL) && ref_pin_sync; // RQ18
        end
    end

    // backplane clock oscillator at 2.048 MHz times 1, 2, 4 or 8
    assign bp_inc = gtc_pkg::NCO_W'(gtc_pkg::INC_BP_BASE << backplane_clock_select); // RQ4

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bp_phase_q <= '0;
            bp_clk_prev_q <= 1'b0;
            backplane_clock_out <= 1'b0;
        end else begin
            bp_phase_q <= bp_phase_q + bp_inc;
            bp_clk_prev_q <= bp_phase_q[gtc_pkg::NCO_W-1];
            backplane_clock_out <= bp_phase_q[gtc_pkg::NCO_W-1];
        end
    end

    assign bp_rise = bp_phase_q[gtc_pkg::NCO_W-1] & ~bp_clk_prev_q;
    assign frame_last = 11'((gtc_pkg::FRAME_BASE_EDGES << backplane_clock_select) - 1);

    // 8 kHz frame pulse, one backplane period wide, aligned to backplane edges
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            frame_count_q <= '0;
            frame_pulse_q <= 1'b0;
        end else if (bp_rise) begin
            frame_count_q <= (frame_count_q >= frame_last) ? 11'h000 : frame_count_q + 11'h001;
            frame_pulse_q <= (frame_count_q == 11'h000); // RQ10
        end
    end

    // transmit sync pin direction; input mode relies on an outside pulse (RQ11)
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tx_system_sync_pin_oe <= 1'b0;
            tx_system_sync_pin_out <= 1'b0;
            tx_frame_sync <= 1'b0;
        end else begin
            tx_system_sync_pin_oe <= tx_sync_direction_select; // RQ10
            tx_system_sync_pin_out <= frame_pulse_q;
            tx_frame_sync <= tx_sync_direction_select ? frame_pulse_q : tx_sync_pin_sync;
        end
    end

    assign selected_loss = loss_source_select ? rx_line_loss : framer_loss; // RQ6

    // shared per-port pin functions
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            loss_or_freeze_pin <= '0;
            rx_sync_pin <= '0;
            tx_channel_pin <= '0;
            rx_channel_pin <= '0;
        end else begin
            loss_or_freeze_pin <= loss_freeze_pin_select ? rx_signaling_freeze : selected_loss; // RQ5
            rx_sync_pin <= rx_sync_pin_select ? rx_multiframe_sync : rx_frame_sync; // RQ7
            tx_channel_pin <= tx_block_clock_select ? tx_channel_clock : tx_channel_block; // RQ8
            rx_channel_pin <= rx_block_clock_select ? rx_channel_clock : rx_channel_block; // RQ9
        end
    end

endmodule : gtc_top

// file: verif/gtc_monitor.sv
// checker for gtc_top: register echo and configuration outputs
// assumes a bind to gtc_top, one mclk domain
`timescale 1ns/1ps
module gtc_monitor #(
    parameter int unsigned PORTS = 8
) (
    // clock, reset, register port
    input logic mclk,
    input logic rst,
    input logic [11:0] reg_addr,
    input logic [7:0] reg_wr_data,
    input logic reg_wr,
    input logic reg_rd,
    input logic [7:0] reg_rd_data,
    // configuration outputs
    input logic irq_unmasked_any,
    input logic interrupt_out_n,
    input logic [1:0] interleave_mux_mode,
    input logic [3:0] interleaved_bus_devices,
    input logic [14:0] master_clock_khz,
    input logic reference_clock_pin_oe,
    input logic backplane_reference_is_t1,
    input logic tx_system_sync_pin_oe,
    // shared pins
    input logic [PORTS-1:0] framer_loss,
    input logic [PORTS-1:0] rx_line_loss,
    input logic [PORTS-1:0] rx_signaling_freeze,
    input logic [PORTS-1:0] loss_or_freeze_pin,
    input logic [PORTS-1:0] rx_frame_sync,
    input logic [PORTS-1:0] rx_multiframe_sync,
    input logic [PORTS-1:0] rx_sync_pin
);
    logic [7:0] c_q [4];
    logic [7:0] rd_exp;
    // shadow of the four registers, unused bits dropped
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            c_q <= '{default: 8'h00};
        end else if (reg_wr && reg_addr[11:2] == 10'h03C) begin
            c_q[reg_addr[1:0]] <= reg_wr_data & (reg_addr[1:0] == 2'h0 ? 8'h01 :
                reg_addr[1:0] == 2'h2 ? 8'h06 : 8'hFF);
        end
    end
    // what a read of the present address returns
    assign rd_exp = reg_addr[11:2] == 10'h03C ? c_q[reg_addr[1:0]] : 8'h00;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    AST_READ_ECHO: assert property (
        reg_rd_data == ($past(reg_rd) ? $past(rd_exp) : 8'h00)) else $error("read data");
    AST_INHIBIT: assert property (
        interrupt_out_n == !($past(irq_unmasked_any) && !$past(c_q[0][0]))) else $error("irq pin");
    AST_LOSS_FREEZE: assert property (loss_or_freeze_pin ==
        $past(c_q[1][3] ? rx_signaling_freeze : c_q[2][2] ? rx_line_loss : framer_loss))
        else $error("loss pins");
    AST_SYNC_PIN: assert property (
        rx_sync_pin == $past(c_q[1][2] ? rx_multiframe_sync : rx_frame_sync)) else $error("sync pins");
    AST_MUX_MODE: assert property (interleave_mux_mode == $past(c_q[1][7:6]) &&
        interleaved_bus_devices == (interleave_mux_mode == 2'h0 ? 4'h0 : 4'h1 << interleave_mux_mode))
        else $error("mux mode");
    AST_MASTER: assert property (master_clock_khz ==
        ($past(c_q[3][2]) ? 15'h0608 : 15'h0800) << $past(c_q[3][1:0])) else $error("master rate");
    AST_SYNC_DIR: assert property (
        tx_system_sync_pin_oe == $past(c_q[2][1])) else $error("sync direction");
    AST_REF_PIN: assert property (backplane_reference_is_t1 == $past(c_q[3][3]) &&
        reference_clock_pin_oe == $past(c_q[3][7:3] == 5'h11 || c_q[3][7:3] == 5'h12))
        else $error("reference pin");
    // main scenarios
    cover property (reg_rd && reg_addr == 12'h0F3);
    cover property (c_q[0][0] && irq_unmasked_any);
    cover property (reference_clock_pin_oe);
endmodule : gtc_monitor

bind gtc_top gtc_monitor #(.PORTS(PORTS)) gtc_monitor_inst (.*);

// file: verif/tb_gtc_top.sv
// testbench for gtc_top: registers, pin steering, reference codes, clock rates
// assumes gtc_pkg and gtc_monitor compiled before it
`timescale 1ns/1ps
module tb_gtc_top;
    logic mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, irq_unmasked_any = 1'b0;
    logic reference_clock_pin_in = 1'b0, tx_system_sync_pin_in = 1'b0;
    logic [11:0] reg_addr = 12'h000, ad;
    logic [7:0] reg_wr_data = 8'h00, rx_recovered_clock = 8'h00, framer_loss = 8'h00;
    logic [7:0] rx_line_loss = 8'h00, rx_signaling_freeze = 8'h00, rx_frame_sync = 8'h00;
    logic [7:0] rx_multiframe_sync = 8'h00, tx_channel_block = 8'h00, tx_channel_clock = 8'h00;
    logic [7:0] rx_channel_block = 8'h00, rx_channel_clock = 8'h00;
    logic [7:0] reg_rd_data, loss_or_freeze_pin, rx_sync_pin, tx_channel_pin, rx_channel_pin;
    logic [1:0] interleave_mux_mode, master_period_select;
    logic [3:0] interleaved_bus_devices;
    logic [14:0] master_clock_khz;
    logic interrupt_out_n, interleaved_bus_enable, master_frequency_family;
    logic reference_clock_pin_out, reference_clock_pin_oe, backplane_clock_out;
    logic backplane_reference_clock, backplane_reference_is_t1, backplane_reference_valid;
    logic tx_system_sync_pin_out, tx_system_sync_pin_oe, tx_frame_sync, pb, pf;
    logic [7:0] m [4] = '{default: 8'h00};
    int fail_count = 0, compares = 0, n_bp, n_fs, code;

    gtc_top #(.PORTS(8)) gtc_top_inst (.*);

    // 40 MHz master clock
    always #12.5 mclk = ~mclk;

    task automatic chk(input string nm, input logic [14:0] exp, input logic [14:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic test_done();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done

    // one write cycle, then an idle cycle; model keeps implemented bits only
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wr_data <= d;
        reg_wr <= 1'b1;
        if (a[11:2] == 10'h03C) m[a[1:0]] = d & (a[1:0] == 2'h0 ? 8'h01 : a[1:0] == 2'h2 ? 8'h06 : 8'hFF);
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask : wr

    // one read cycle, data checked in the answer cycle
    task automatic rd(input logic [11:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        chk("reg_rd_data", a[11:2] == 10'h03C ? m[a[1:0]] : 8'h00, reg_rd_data);
        @(posedge mclk);
    endtask : rd

    // run watchdog
    initial begin
        repeat (100000) @(posedge mclk);
        fail_count++;
        test_done();
    end

    // main sequence
    initial begin
        void'($urandom(18388));
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        for (int a = 0; a < 4; a++) rd(12'h0F0 + 12'(a));
        repeat (40) begin
            ad = 12'h0F0 + 12'($urandom_range(0, 7));
            wr(ad, 8'($urandom));
            rd(ad);
        end
        repeat (30) begin
            {framer_loss, rx_line_loss, rx_signaling_freeze, rx_frame_sync} <= $urandom;
            {rx_multiframe_sync, tx_channel_block, tx_channel_clock, rx_channel_block} <= $urandom;
            rx_channel_clock <= 8'($urandom);
            irq_unmasked_any <= 1'($urandom);
            wr(12'h0F0, 8'($urandom) & 8'h01);
            wr(12'h0F1, 8'($urandom));
            wr(12'h0F2, 8'($urandom) & 8'h06);
            wr(12'h0F3, 8'($urandom) & 8'h0F);
            @(negedge mclk);
            chk("irq_n", !(irq_unmasked_any && !m[0][0]), interrupt_out_n);
            chk("loss_pin", m[1][3] ? rx_signaling_freeze :
                m[2][2] ? rx_line_loss : framer_loss, loss_or_freeze_pin);
            chk("sync_pin", m[1][2] ? rx_multiframe_sync : rx_frame_sync, rx_sync_pin);
            chk("tx_chan", m[1][1] ? tx_channel_clock : tx_channel_block, tx_channel_pin);
            chk("rx_chan", m[1][0] ? rx_channel_clock : rx_channel_block, rx_channel_pin);
            chk("mux_dev", {m[1][7:6] != 2'h0, m[1][7:6] == 2'h0 ? 4'h0 : 4'h1 << m[1][7:6]},
                {interleaved_bus_enable, interleaved_bus_devices});
            chk("mclk_khz", (m[3][2] ? 15'h0608 : 15'h0800) << m[3][1:0], master_clock_khz);
            chk("mclk_sel", m[3][2:0], {master_frequency_family, master_period_select});
            chk("sync_oe", m[2][1], tx_system_sync_pin_oe);
        end
        for (int c = 0; c < 32; c++) begin
            rx_recovered_clock <= 8'($urandom);
            reference_clock_pin_in <= 1'($urandom);
            wr(12'h0F3, 8'(c << 3));
            repeat (8) @(posedge mclk);
            @(negedge mclk);
            code = c >> 1;
            chk("ref_valid", code < 8 || code == 10 || code == 9 - c % 2, backplane_reference_valid);
            chk("ref_oe", code == 9 - c % 2, reference_clock_pin_oe);
            chk("ref_t1", c % 2, backplane_reference_is_t1);
            if (code != 8 && code != 9) chk("ref_clk", code < 8 ? rx_recovered_clock[code] :
                code == 10 && reference_clock_pin_in, backplane_reference_clock);
        end
        for (int s = 0; s < 4; s++) begin
            wr(12'h0F2, 8'h02);
            wr(12'h0F1, 8'(s << 4));
            n_bp = 0;
            n_fs = 0;
            // count rises over 10000 cycles
            repeat (10000) begin
                @(negedge mclk);
                if (backplane_clock_out && !pb) n_bp++;
                if (tx_system_sync_pin_out && !pf) n_fs++;
                pb = backplane_clock_out;
                pf = tx_system_sync_pin_out;
            end
            chk("bp_rises", 1, n_bp >= (512 << s) - 2 && n_bp <= (512 << s) + 2);
            chk("frame_pulses", 1, n_fs >= 1 && n_fs <= 3);
        end
        wr(12'h0F2, 8'h00);
        tx_system_sync_pin_in <= 1'b1;
        repeat (8) @(posedge mclk);
        @(negedge mclk);
        chk("frame_in", 1, tx_frame_sync);
        test_done();
    end
endmodule : tb_gtc_top
